// *** logic/port_pin_alt_regs.vh ***
// Constants for the port pin alternate function override block
`ifndef PORT_PIN_ALT_REGS_VH
`define PORT_PIN_ALT_REGS_VH

`define PORT_WIDTH 8
`define DIR_RESET 8'h00
`define LATCH_RESET 8'h00
`define SYNC_RESET 8'h00
`define PULLUP_ON_CODE 3'h2
`define READ_ZERO 1'b0
`define BIT_OSC_OUT 7
`define BIT_OSC_IN 6
`define BIT_SPI_CLK 5
`define BIT_SPI_MISO 4
`define BIT_SPI_MOSI 3
`define BIT_PCSRC_LOW 3
`define PCSRC_WIDTH 5

`endif

// *** logic/port_pin_alt_function_override.v ***
// Port pin override logic with alternate functions of bits 7 to 3
// Notes on behaviour
// - Pull-up follows override, else code 010
// - Override value alone switches pull-up
// - Driver enable from override or direction bit
// - Direction override value turns driver on/off
// - Driven value from override or latch
// - Value override ignores output latch
// - Input enable from override, else sleep state
// - Input override value ignores sleep state
// - Raw input taken before port synchroniser
// - Strobes shared per port, others per pin
// - Bit 7 as clock pin reads zero
// - Timer crystal mode takes bit 7 off port
// - Async timer takes bit 6 off port
// - Bit 6 as clock pin reads zero
// - SPI slave forces clock pin input
// - Forced input keeps latch pull-up control
// - SPI master forces data-in pin input
// - SPI slave forces data-out pin input
// - Pins 7 to 3 feed pin-change sources
// - Direction bit 1 output, 0 input
`include "port_pin_alt_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module port_pin_alt_function_override #(
	parameter WIDTH = `PORT_WIDTH
) (
	input wire clk_sys,
	input wire rst_n,
	input wire dirWrite,
	input wire latchWrite,
	input wire pinToggleWrite,
	input wire [WIDTH-1:0] writeData,
	input wire sleepClamp,
	input wire globalPullupDisable,
	input wire [WIDTH-1:0] pullupOverrideEn,
	input wire [WIDTH-1:0] pullupOverrideVal,
	input wire [WIDTH-1:0] dirOverrideEn,
	input wire [WIDTH-1:0] dirOverrideVal,
	input wire [WIDTH-1:0] valueOverrideEn,
	input wire [WIDTH-1:0] valueOverrideVal,
	input wire [WIDTH-1:0] inputEnOverrideEn,
	input wire [WIDTH-1:0] inputEnOverrideVal,
	input wire intRcSelected,
	input wire extClockSelected,
	input wire asyncTimer2Select,
	input wire extClockForAsyncTimer,
	input wire spiEnable,
	input wire spiMaster,
	input wire sckOut,
	input wire spiSlaveOut,
	input wire spiMasterOut,
	input wire compare2aEnable,
	input wire compare2aWaveOut,
	input wire [`PCSRC_WIDTH-1:0] pinChangeMask,
	input wire pinChangeEnable,
	input wire [WIDTH-1:0] padIn,
	output wire [WIDTH-1:0] padOut,
	output wire [WIDTH-1:0] padOutEn_n,
	output wire [WIDTH-1:0] pullupEn,
	output wire [WIDTH-1:0] altRawInput,
	output wire [`PCSRC_WIDTH-1:0] pinChangeSrc,
	output wire oscOutTakeover,
	output wire oscInTakeover,
	output wire [WIDTH-1:0] dirReadback,
	output wire [WIDTH-1:0] latchReadback,
	output wire [WIDTH-1:0] pinInputReadback
);

	// Two-way choice used by every override pair
	function sel;
		input en;
		input val;
		input dflt;
		begin
			sel = en ? val : dflt;
		end
	endfunction

	// Pull-up of an SPI pin while SPI owns it
	// Latch decides unless SPI leaves direction free and it is set
	function spiPull;
		input latch;
		input dir;
		input dirFree;
		input global_pullup_disable;
		begin
			spiPull = latch & ~(dir & dirFree) & ~global_pullup_disable;
		end
	endfunction

	reg [WIDTH-1:0] pinDirection;
	reg [WIDTH-1:0] pinOutputLatch;
	reg [WIDTH-1:0] syncStage1;
	reg [WIDTH-1:0] pinInput;

	// Strobes and data are one set for the whole port
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			pinDirection <= `DIR_RESET;
			pinOutputLatch <= `LATCH_RESET;
		end else begin
			if (dirWrite) begin
				pinDirection <= writeData;
			end
			if (latchWrite) begin
				pinOutputLatch <= writeData;
			end else if (pinToggleWrite) begin
				pinOutputLatch <= pinOutputLatch ^ writeData;
			end
		end
	end

	// Alternate function sources of the upper pins
	wire osc7 = (~intRcSelected & ~extClockSelected) |
		(asyncTimer2Select & ~extClockForAsyncTimer);
	wire osc6 = ~intRcSelected | asyncTimer2Select;
	wire spiSlave = spiEnable & ~spiMaster;
	wire spiMst = spiEnable & spiMaster;
	wire [`PCSRC_WIDTH-1:0] pcOn = pinChangeMask &
		{`PCSRC_WIDTH{pinChangeEnable}};

	reg [WIDTH-1:0] pullup_override_en;
	reg [WIDTH-1:0] pullup_override_val;
	reg [WIDTH-1:0] dir_override_en;
	reg [WIDTH-1:0] dir_override_val;
	reg [WIDTH-1:0] value_override_en;
	reg [WIDTH-1:0] value_override_val;
	reg [WIDTH-1:0] input_en_override_en;
	reg [WIDTH-1:0] input_en_override_val;
	reg [WIDTH-1:0] clockPin;

	always @* begin
		pullup_override_en = pullupOverrideEn;
		pullup_override_val = pullupOverrideVal;
		dir_override_en = dirOverrideEn;
		dir_override_val = dirOverrideVal;
		value_override_en = valueOverrideEn;
		value_override_val = valueOverrideVal;
		input_en_override_en = inputEnOverrideEn;
		input_en_override_val = inputEnOverrideVal;
		clockPin = {WIDTH{1'b0}};
		// Oscillator pin 7: driver, pull-up and input all off
		clockPin[`BIT_OSC_OUT] = osc7;
		if (osc7) begin
			pullup_override_en[`BIT_OSC_OUT] = 1'b1;
			pullup_override_val[`BIT_OSC_OUT] = 1'b0;
			dir_override_en[`BIT_OSC_OUT] = 1'b1;
			dir_override_val[`BIT_OSC_OUT] = 1'b0;
			value_override_en[`BIT_OSC_OUT] = 1'b0;
			input_en_override_en[`BIT_OSC_OUT] = 1'b1;
			input_en_override_val[`BIT_OSC_OUT] = 1'b0;
		end else if (pcOn[`BIT_OSC_OUT-`BIT_PCSRC_LOW]) begin
			input_en_override_en[`BIT_OSC_OUT] = 1'b1;
			input_en_override_val[`BIT_OSC_OUT] = 1'b1;
		end
		// Oscillator pin 6 keeps no digital path either
		clockPin[`BIT_OSC_IN] = osc6;
		if (osc6) begin
			pullup_override_en[`BIT_OSC_IN] = 1'b1;
			pullup_override_val[`BIT_OSC_IN] = 1'b0;
			dir_override_en[`BIT_OSC_IN] = 1'b1;
			dir_override_val[`BIT_OSC_IN] = 1'b0;
			value_override_en[`BIT_OSC_IN] = 1'b0;
			input_en_override_en[`BIT_OSC_IN] = 1'b1;
			input_en_override_val[`BIT_OSC_IN] = 1'b0;
		end else if (pcOn[`BIT_OSC_IN-`BIT_PCSRC_LOW]) begin
			input_en_override_en[`BIT_OSC_IN] = 1'b1;
			input_en_override_val[`BIT_OSC_IN] = 1'b1;
		end
		// SPI clock: input as slave, SPI drives it as master if dir set
		if (spiSlave) begin
			dir_override_en[`BIT_SPI_CLK] = 1'b1;
			dir_override_val[`BIT_SPI_CLK] = 1'b0;
		end else if (spiMst) begin
			value_override_en[`BIT_SPI_CLK] = 1'b1;
			value_override_val[`BIT_SPI_CLK] = sckOut;
		end
		// SPI data in: input as master, slave drives if dir set
		if (spiMst) begin
			dir_override_en[`BIT_SPI_MISO] = 1'b1;
			dir_override_val[`BIT_SPI_MISO] = 1'b0;
		end else if (spiSlave) begin
			value_override_en[`BIT_SPI_MISO] = 1'b1;
			value_override_val[`BIT_SPI_MISO] = spiSlaveOut;
		end
		// SPI data out, shared with the compare output
		if (spiSlave) begin
			dir_override_en[`BIT_SPI_MOSI] = 1'b1;
			dir_override_val[`BIT_SPI_MOSI] = 1'b0;
		end else if (spiMst) begin
			value_override_en[`BIT_SPI_MOSI] = 1'b1;
			value_override_val[`BIT_SPI_MOSI] = spiMasterOut;
		end else if (compare2aEnable) begin
			// Reaches the pad only once software sets direction
			value_override_en[`BIT_SPI_MOSI] = 1'b1;
			value_override_val[`BIT_SPI_MOSI] = compare2aWaveOut;
		end
		if (spiEnable) begin
			// Pull-up stays with the latch while forced input
			pullup_override_en[`BIT_SPI_CLK] = 1'b1;
			// Slave forces clock input, so direction bit is ignored
			pullup_override_val[`BIT_SPI_CLK] = spiPull(pinOutputLatch[`BIT_SPI_CLK],
				pinDirection[`BIT_SPI_CLK], spiMst,
				globalPullupDisable);
			pullup_override_en[`BIT_SPI_MISO] = 1'b1;
			pullup_override_val[`BIT_SPI_MISO] = spiPull(pinOutputLatch[`BIT_SPI_MISO],
				pinDirection[`BIT_SPI_MISO], spiSlave,
				globalPullupDisable);
			pullup_override_en[`BIT_SPI_MOSI] = 1'b1;
			pullup_override_val[`BIT_SPI_MOSI] = spiPull(pinOutputLatch[`BIT_SPI_MOSI],
				pinDirection[`BIT_SPI_MOSI], spiMst,
				globalPullupDisable);
		end
		if (pcOn[`BIT_SPI_CLK-`BIT_PCSRC_LOW]) begin
			input_en_override_en[`BIT_SPI_CLK] = 1'b1;
			input_en_override_val[`BIT_SPI_CLK] = 1'b1;
		end
		if (pcOn[`BIT_SPI_MISO-`BIT_PCSRC_LOW]) begin
			input_en_override_en[`BIT_SPI_MISO] = 1'b1;
			input_en_override_val[`BIT_SPI_MISO] = 1'b1;
		end
		if (pcOn[`BIT_SPI_MOSI-`BIT_PCSRC_LOW]) begin
			input_en_override_en[`BIT_SPI_MOSI] = 1'b1;
			input_en_override_val[`BIT_SPI_MOSI] = 1'b1;
		end
	end

	wire [WIDTH-1:0] inBuf;
	wire [WIDTH-1:0] driverOn;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
			wire puCode = ({pinDirection[i], pinOutputLatch[i],
				globalPullupDisable} == `PULLUP_ON_CODE);
			wire dieOn = sel(input_en_override_en[i], input_en_override_val[i], ~sleepClamp);
			assign pullupEn[i] = sel(pullup_override_en[i], pullup_override_val[i], puCode);
			assign driverOn[i] = sel(dir_override_en[i], dir_override_val[i],
				pinDirection[i]);
			assign padOut[i] = sel(value_override_en[i], value_override_val[i],
				pinOutputLatch[i]);
			assign padOutEn_n[i] = ~driverOn[i];
			// Clamped to ground while input is disabled
			assign inBuf[i] = padIn[i] & dieOn;
			assign dirReadback[i] = clockPin[i] ? `READ_ZERO :
				pinDirection[i];
			assign latchReadback[i] = clockPin[i] ? `READ_ZERO :
				pinOutputLatch[i];
			assign pinInputReadback[i] = clockPin[i] ? `READ_ZERO :
				pinInput[i];
		end
	endgenerate

	// Unsynchronised; receivers add their own synchroniser
	assign altRawInput = inBuf;
	assign pinChangeSrc = inBuf[WIDTH-1:`BIT_PCSRC_LOW];
	assign oscOutTakeover = osc7;
	assign oscInTakeover = osc6;

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			syncStage1 <= `SYNC_RESET;
			pinInput <= `SYNC_RESET;
		end else begin
			syncStage1 <= inBuf;
			pinInput <= syncStage1;
		end
	end

endmodule // port_pin_alt_function_override

`default_nettype wire

// *** verification/port_pin_alt_monitor.sv ***
// Assertion checker for the port pin override block
`timescale 1ns/1ps
`default_nettype none
module port_pin_alt_monitor (
	input wire clk_sys, rst_n, dirWrite, globalPullupDisable, spiEnable,
	input wire spiMaster, asyncTimer2Select, extClockForAsyncTimer,
	input wire oscOutTakeover, oscInTakeover,
	input wire [7:0] writeData, pullupOverrideEn, pullupOverrideVal,
	input wire [7:0] dirOverrideEn, dirOverrideVal, valueOverrideEn,
	input wire [7:0] valueOverrideVal, inputEnOverrideEn, inputEnOverrideVal,
	input wire [7:0] padIn, padOut, padOutEn_n, pullupEn, altRawInput,
	input wire [7:0] dirReadback, latchReadback, pinInputReadback
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_DIR_WRITE: assert property (dirWrite |=>
		dirReadback[2:0] == $past(writeData[2:0])) else $error("dir lost");
	AST_DRIVE: assert property (padOutEn_n[0] ==
		!(dirOverrideEn[0] ? dirOverrideVal[0] : dirReadback[0]))
		else $error("driver enable wrong");
	AST_VALUE: assert property (valueOverrideEn[2] && !padOutEn_n[2] |->
		padOut[2] == valueOverrideVal[2]) else $error("value wrong");
	AST_PULLUP: assert property (pullupEn[0] == (pullupOverrideEn[0] ?
		pullupOverrideVal[0] : !dirReadback[0] && latchReadback[0] &&
		!globalPullupDisable)) else $error("pull-up wrong");
	AST_INPUT: assert property (inputEnOverrideEn[0] |->
		altRawInput[0] == (padIn[0] & inputEnOverrideVal[0]))
		else $error("input enable wrong");
	AST_SPI: assert property (spiEnable |-> (spiMaster ?
		padOutEn_n[4] : padOutEn_n[5] && padOutEn_n[3]))
		else $error("spi direction wrong");
	AST_OSC: assert property (asyncTimer2Select |-> oscInTakeover &&
		(extClockForAsyncTimer || oscOutTakeover)) else $error("osc pin");
	AST_CLKPIN: assert property (oscOutTakeover |->
		{dirReadback[7], latchReadback[7], pinInputReadback[7]} == 3'h0)
		else $error("clock pin reads nonzero");
	cover property (spiEnable && spiMaster);
	cover property (asyncTimer2Select);
	cover property (valueOverrideEn[2] && !padOutEn_n[2]);
endmodule // port_pin_alt_monitor
bind port_pin_alt_function_override port_pin_alt_monitor mon_u (.*);
`default_nettype wire

// *** verification/alt_function_model.sv ***
// Behavioural model of the SPI and timer units beside the port
`timescale 1ns/1ps
`default_nettype none
module alt_function_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] altRawInput,
	output logic sckOut, spiMasterOut, spiSlaveOut, compare2aWaveOut, sckSeen
);
	logic [3:0] phase;
	logic [1:0] sckSync;
	// Raw pin input arrives unsynchronised, so resync here
	always @(posedge clk_sys) begin
		phase <= rst_n ? phase + 4'h1 : 4'h0;
		sckSync <= {sckSync[0], altRawInput[5]};
	end
	assign {compare2aWaveOut, spiSlaveOut, spiMasterOut, sckOut} = phase;
	assign sckSeen = sckSync[1];
endmodule // alt_function_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the port pin override block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys = 0, rst_n = 0, dirWrite = 0, latchWrite = 0;
	logic pinToggleWrite = 0, sleepClamp = 0, globalPullupDisable = 0;
	logic intRcSelected = 1, extClockSelected = 0, asyncTimer2Select = 0;
	logic extClockForAsyncTimer = 0, spiEnable = 0, spiMaster = 0;
	logic compare2aEnable = 0, pinChangeEnable = 0, oscOutTakeover;
	logic oscInTakeover, sckOut, spiSlaveOut, spiMasterOut, compare2aWaveOut;
	logic [4:0] pinChangeMask = 5'h00, pinChangeSrc;
	logic [7:0] writeData = 8'h00, padIn = 8'h00, pullupOverrideEn = 8'h00;
	logic [7:0] pullupOverrideVal = 8'h00, dirOverrideEn = 8'h00;
	logic [7:0] dirOverrideVal = 8'h00, valueOverrideEn = 8'h00;
	logic [7:0] valueOverrideVal = 8'h00, inputEnOverrideEn = 8'h00;
	logic [7:0] inputEnOverrideVal = 8'h00, padOut, padOutEn_n, pullupEn;
	logic [7:0] altRawInput, dirReadback, latchReadback, pinInputReadback;
	int bad_count = 0, total_checks = 0, cyc = 0;
	port_pin_alt_function_override dut_u (.*);
	alt_function_model peer_u (.*, .sckSeen());
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 500) begin
			bad_count++;
			print_verdict;
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic d, input logic [7:0] v);
		@(posedge clk_sys);
		dirWrite <= d;
		latchWrite <= !d;
		writeData <= v;
		@(posedge clk_sys);
		dirWrite <= 0;
		latchWrite <= 0;
		#1;
	endtask
	task t_basic;
		wr(1, 8'h0f);
		wr(0, 8'hf5);
		chk(padOutEn_n, 8'hf0);
		chk(padOut & 8'h0f, 8'h05);
		chk(pullupEn, 8'hf0);
		@(posedge clk_sys);
		globalPullupDisable <= 1;
		#1 chk(pullupEn, 8'h00);
		$display("basic done");
	endtask
	task t_override;
		@(posedge clk_sys);
		dirOverrideEn <= 8'h03;
		dirOverrideVal <= 8'h02;
		valueOverrideEn <= 8'h04;
		{pullupOverrideEn, pullupOverrideVal} <= 16'h0101;
		{inputEnOverrideEn, inputEnOverrideVal} <= 16'h0101;
		sleepClamp <= 1;
		padIn <= 8'h03;
		#1 chk(padOutEn_n, 8'hf1);
		chk(padOut & 8'h04, 8'h00);
		chk(pullupEn, 8'h01);
		chk(altRawInput, 8'h01);
		$display("override done");
	endtask
	task t_spi;
		@(posedge clk_sys);
		{dirOverrideEn, valueOverrideEn, pullupOverrideEn} <= 24'h000000;
		{inputEnOverrideEn, sleepClamp} <= 9'h000;
		wr(1, 8'hff);
		@(posedge clk_sys);
		spiEnable <= 1;
		#1 chk(padOutEn_n, 8'h28);
		@(posedge clk_sys);
		spiMaster <= 1;
		#1 chk(padOutEn_n, 8'h10);
		chk(padOut & 8'h20, {2'h0, sckOut, 5'h00});
		@(posedge clk_sys);
		spiEnable <= 0;
		compare2aEnable <= 1;
		#1 chk(padOut & 8'h08, {4'h0, compare2aWaveOut, 3'h0});
		$display("spi done");
	endtask
	task t_clock;
		@(posedge clk_sys);
		compare2aEnable <= 0;
		asyncTimer2Select <= 1;
		#1 chk({6'h00, oscOutTakeover, oscInTakeover}, 8'h03);
		chk(dirReadback & 8'hc0, 8'h00);
		chk(latchReadback & 8'hc0, 8'h00);
		$display("clock pin done");
	endtask
	task t_pin;
		@(posedge clk_sys);
		asyncTimer2Select <= 0;
		{sleepClamp, pinChangeEnable, pinChangeMask} <= 7'h75;
		padIn <= 8'hf8;
		#1 chk({3'h0, pinChangeSrc}, 8'h15);
		@(posedge clk_sys);
		sleepClamp <= 0;
		padIn <= 8'h5a;
		repeat (2) @(posedge clk_sys);
		#1 chk(pinInputReadback, 8'h5a);
		$display("pin input done");
	endtask
	task t_toggle;
		@(posedge clk_sys);
		pinToggleWrite <= 1;
		writeData <= 8'h0f;
		@(posedge clk_sys);
		pinToggleWrite <= 0;
		#1 chk(latchReadback, 8'hfa);
		@(posedge clk_sys);
		{latchWrite, pinToggleWrite} <= 2'h3;
		writeData <= 8'h33;
		@(posedge clk_sys);
		{latchWrite, pinToggleWrite} <= 2'h0;
		#1 chk(latchReadback, 8'h33);
		@(posedge clk_sys);
		spiEnable <= 1;
		spiMaster <= 0;
		globalPullupDisable <= 0;
		#1 chk(padOutEn_n, 8'h28);
		chk(padOut & 8'h10, {3'h0, spiSlaveOut, 4'h0});
		chk(pullupEn, 8'h20);
		$display("toggle and slave done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1;
		t_basic;
		t_override;
		t_spi;
		t_clock;
		t_pin;
		t_toggle;
		print_verdict;
	end
endmodule // tb
`default_nettype wire
